// ### inc/plc_gates_consts.vh
// Constants for the scan-based basic gates and exchange flag bank.
//
// Contract
// - AND output high only when all high
// - Unconnected gate inputs count as logic high
// - Edge AND fires when all high, previously not
// - Edge AND pulse lasts exactly one scan
// - Edge AND low at least one scan after
// - NAND output low only when all high (reset drives it low before the first scan)
// - Each gate input individually invertible
// - Digital flag holds one bit
// - Analog flag holds signed short value
// - Sixty-four digital and sixty-four analog flags
// - Flags exchangeable with partner, master or slave
// - Duplicate flag number configuration is rejected
// - Flag output shows previous scan value
// - Failed communication leaves flags unchanged
// - First scan flag high only first scan
`ifndef PLC_GATES_CONSTS_VH
`define PLC_GATES_CONSTS_VH

`define GATE_INPUTS        4
`define FLAG_COUNT         64
`define FLAG_IDX_W         6
`define AFLAG_W            16
`define FIRST_SCAN_IDX     6'h07
`define UNUSED_INPUT_LEVEL 1'b1
`define AFLAG_RESET        16'h0000
`define DFLAG_RESET        1'b0
`define GATE_LOW           1'b0
`define FIRST_SCAN_LEVEL   1'b1
`define FLAGS_RESET        64'h0000000000000000
`define ONE_HOT_BASE       64'h0000000000000001
`define PHASE_START_CODE   3'b001
`define PHASE_FIRST_CODE   3'b010
`define PHASE_RUN_CODE     3'b100

`endif

// ### verilog/plc_basic_gates_and_flags.v
// Scan-based basic gates and exchange flag bank.
`timescale 1ns/10ps
`include "plc_gates_consts.vh"

module plc_basic_gates_and_flags (
   input  wire                     I_CLK,
   input  wire                     I_RST,
   input  wire                     I_SCAN,
   input  wire [3:0]               I_GATE_IN,
   input  wire [3:0]               I_GATE_USED,
   input  wire [3:0]               I_GATE_INV,
   output reg                      O_AND,
   output reg                      O_AND_EDGE,
   output reg                      O_NAND,
   input  wire                     I_CFG_VALID,
   input  wire [5:0]               I_CFG_NUM,
   input  wire                     I_CFG_ANALOG,
   output reg                      O_CFG_REJECT,
   input  wire                     I_LOC_WR,
   input  wire                     I_LOC_ANALOG,
   input  wire [5:0]               I_LOC_NUM,
   input  wire                     I_LOC_DBIT,
   input  wire [15:0]              I_LOC_AVAL,
   input  wire                     I_COM_OK,
   input  wire                     I_COM_WR,
   input  wire                     I_COM_ANALOG,
   input  wire [5:0]               I_COM_NUM,
   input  wire                     I_COM_DBIT,
   input  wire [15:0]              I_COM_AVAL,
   input  wire [5:0]               I_RD_NUM,
   output reg                      O_RD_DBIT,
   output reg  [15:0]              O_RD_AVAL,
   output wire [63:0]              O_DFLAGS
);

   // ----------------------------------------------------------------
   // Gate input conditioning
   // ----------------------------------------------------------------

   wire [3:0]  raw_lvl;
   wire [3:0]  eff;
   wire        all_high;

   genvar g;
   generate
      for (g = 0; g < `GATE_INPUTS; g = g + 1) begin : cond
         assign raw_lvl[g] = I_GATE_IN[g] ^ I_GATE_INV[g];
         assign eff[g]     = I_GATE_USED[g] ? raw_lvl[g] : `UNUSED_INPUT_LEVEL;
      end
   endgenerate

   assign all_high = &eff;

   // ----------------------------------------------------------------
   // Scan phase next state
   // ----------------------------------------------------------------

   localparam [2:0] PH_START = `PHASE_START_CODE;
   localparam [2:0] PH_FIRST = `PHASE_FIRST_CODE;
   localparam [2:0] PH_RUN   = `PHASE_RUN_CODE;

   reg  [2:0]  phase_q;
   reg  [2:0]  phase_d;
   wire        first_scan;
   wire        have_prev;

   always @* begin
      phase_d = phase_q;
      case (phase_q)
         PH_START: begin
            if (I_SCAN) begin
               phase_d = PH_FIRST;
            end
         end
         PH_FIRST: begin
            if (I_SCAN) begin
               phase_d = PH_RUN;
            end
         end
         PH_RUN: begin
            phase_d = PH_RUN;
         end
         default: begin
            phase_d = PH_START;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Scan phase register
   // ----------------------------------------------------------------

   always @(posedge I_CLK) begin
      if (I_RST) begin
         phase_q <= PH_START;
      end else begin
         phase_q <= phase_d;
      end
   end

   // ----------------------------------------------------------------
   // Scan history
   // ----------------------------------------------------------------

   assign first_scan = (phase_q == PH_START);
   assign have_prev  = ~first_scan;

   // ----------------------------------------------------------------
   // Gate next values
   // ----------------------------------------------------------------

   reg         and_d;
   reg         nand_d;
   reg         edge_d;
   reg         prev_all_d;
   reg         prev_all_q;

   always @* begin
      and_d      = O_AND;
      nand_d     = O_NAND;
      edge_d     = O_AND_EDGE;
      prev_all_d = prev_all_q;
      if (I_SCAN) begin
         and_d      = all_high;
         nand_d     = ~all_high;
         edge_d     = all_high & have_prev & ~prev_all_q & ~O_AND_EDGE;
         prev_all_d = all_high;
      end
   end

   // ----------------------------------------------------------------
   // Gate output registers
   // ----------------------------------------------------------------

   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_AND      <= `GATE_LOW;
         O_AND_EDGE <= `GATE_LOW;
         O_NAND     <= `GATE_LOW;
         prev_all_q <= `GATE_LOW;
      end else begin
         O_AND      <= and_d;
         O_AND_EDGE <= edge_d;
         O_NAND     <= nand_d;
         prev_all_q <= prev_all_d;
      end
   end

   // ----------------------------------------------------------------
   // Flag number allocation
   // ----------------------------------------------------------------

   reg  [63:0] dnum_used_q;
   reg  [63:0] anum_used_q;
   wire [63:0] dnum_used_d;
   wire [63:0] anum_used_d;
   wire [63:0] cfg_sel;
   wire        dup;
   wire        claim_ok;
   wire        reject_d;

   assign cfg_sel  = `ONE_HOT_BASE << I_CFG_NUM;
   assign dup      = I_CFG_ANALOG ? anum_used_q[I_CFG_NUM] : dnum_used_q[I_CFG_NUM];
   assign claim_ok = I_CFG_VALID & ~dup;
   assign reject_d = I_CFG_VALID & dup;

   genvar n;
   generate
      for (n = 0; n < `FLAG_COUNT; n = n + 1) begin : alloc
         wire claim_d = claim_ok & cfg_sel[n] & ~I_CFG_ANALOG;
         wire claim_a = claim_ok & cfg_sel[n] & I_CFG_ANALOG;
         assign dnum_used_d[n] = dnum_used_q[n] | claim_d;
         assign anum_used_d[n] = anum_used_q[n] | claim_a;
      end
   endgenerate

   always @(posedge I_CLK) begin
      if (I_RST) begin
         dnum_used_q  <= `FLAGS_RESET;
         anum_used_q  <= `FLAGS_RESET;
         O_CFG_REJECT <= `GATE_LOW;
      end else begin
         dnum_used_q  <= dnum_used_d;
         anum_used_q  <= anum_used_d;
         O_CFG_REJECT <= reject_d;
      end
   end

   // ----------------------------------------------------------------
   // Local program writes
   // ----------------------------------------------------------------

   wire [63:0] loc_sel;
   wire        loc_dwr;
   wire        loc_awr;

   assign loc_sel = `ONE_HOT_BASE << I_LOC_NUM;
   assign loc_dwr = I_LOC_WR & ~I_LOC_ANALOG;
   assign loc_awr = I_LOC_WR & I_LOC_ANALOG;

   // ----------------------------------------------------------------
   // Partner writes
   // ----------------------------------------------------------------

   wire [63:0] com_sel;
   wire        com_go;
   wire        com_dwr;
   wire        com_awr;

   assign com_sel = `ONE_HOT_BASE << I_COM_NUM;
   assign com_go  = I_COM_WR & I_COM_OK;
   assign com_dwr = com_go & ~I_COM_ANALOG;
   assign com_awr = com_go & I_COM_ANALOG;

   // ----------------------------------------------------------------
   // Digital flags: working copy and scan-latched output copy
   // ----------------------------------------------------------------

   reg  [63:0] dwork_q;
   wire [63:0] dwork_d;
   reg  [63:0] dout_q;
   wire [63:0] dout_d;

   assign O_DFLAGS = dout_q;

   generate
      for (n = 0; n < `FLAG_COUNT; n = n + 1) begin : dflag
         wire com_hit = com_dwr & com_sel[n];
         wire loc_hit = loc_dwr & loc_sel[n];

         assign dwork_d[n] = com_hit ? I_COM_DBIT :
                             loc_hit ? I_LOC_DBIT : dwork_q[n];
         if (n == `FIRST_SCAN_IDX) begin : startup
            assign dout_d[n] = I_SCAN ? (first_scan ? `FIRST_SCAN_LEVEL : dwork_q[n])
                                      : dout_q[n];
         end else begin : plain
            assign dout_d[n] = I_SCAN ? dwork_q[n] : dout_q[n];
         end
      end
   endgenerate

   always @(posedge I_CLK) begin
      if (I_RST) begin
         dwork_q <= `FLAGS_RESET;
         dout_q  <= `FLAGS_RESET;
      end else begin
         dwork_q <= dwork_d;
         dout_q  <= dout_d;
      end
   end

   // ----------------------------------------------------------------
   // Analog flags: working copy and scan-latched output copy
   // ----------------------------------------------------------------

   reg [15:0] awork_q [0:`FLAG_COUNT-1];
   reg [15:0] aout_q  [0:`FLAG_COUNT-1];

   genvar a;
   generate
      for (a = 0; a < `FLAG_COUNT; a = a + 1) begin : aflag
         wire        com_hit = com_awr & com_sel[a];
         wire        loc_hit = loc_awr & loc_sel[a];
         wire [15:0] awork_d;
         wire [15:0] aout_d;

         assign awork_d = com_hit ? I_COM_AVAL :
                          loc_hit ? I_LOC_AVAL : awork_q[a];
         assign aout_d  = I_SCAN ? awork_q[a] : aout_q[a];

         always @(posedge I_CLK) begin
            if (I_RST) begin
               awork_q[a] <= `AFLAG_RESET;
               aout_q[a]  <= `AFLAG_RESET;
            end else begin
               awork_q[a] <= awork_d;
               aout_q[a]  <= aout_d;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Partner read port
   // ----------------------------------------------------------------

   reg         rd_dbit_d;
   reg  [15:0] rd_aval_d;

   always @* begin
      rd_dbit_d = dout_q[I_RD_NUM];
      rd_aval_d = aout_q[I_RD_NUM];
   end

   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_RD_DBIT <= `DFLAG_RESET;
         O_RD_AVAL <= `AFLAG_RESET;
      end else begin
         O_RD_DBIT <= rd_dbit_d;
         O_RD_AVAL <= rd_aval_d;
      end
   end

endmodule // plc_basic_gates_and_flags

// ### tb/plc_gates_properties.sv
// Checker for the scan gate block.
`timescale 1ns/10ps
module plc_gates_chk (
   input wire I_CLK, I_RST, I_SCAN, O_AND, O_AND_EDGE, O_NAND, I_CFG_VALID, O_CFG_REJECT,
   input wire [3:0] I_GATE_IN, I_GATE_USED, I_GATE_INV,
   input wire [63:0] O_DFLAGS
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   wire hi = &(~I_GATE_USED | (I_GATE_IN ^ I_GATE_INV));
   sequence s_fire; I_SCAN ##1 O_AND_EDGE; endsequence
   property p_and; I_SCAN |=> O_AND == $past(hi); endproperty
   a_and: assert property (p_and) else $error("and");
   property p_nand; I_SCAN |=> O_NAND != $past(hi); endproperty
   a_nand: assert property (p_nand) else $error("nand");
   property p_hold; !I_SCAN |=> $stable({O_AND, O_NAND, O_AND_EDGE}); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_pulse; s_fire ##0 I_SCAN |=> !O_AND_EDGE; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_edge; $rose(O_AND_EDGE) |-> O_AND && !$past(O_AND); endproperty
   a_edge: assert property (p_edge) else $error("edge");
   property p_rst; disable iff (1'b0) I_RST |=> !(O_AND | O_AND_EDGE | O_NAND); endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_flag; !I_SCAN |=> $stable(O_DFLAGS); endproperty
   a_flag: assert property (p_flag) else $error("flag");
   property p_rej; O_CFG_REJECT |-> $past(I_CFG_VALID); endproperty
   a_rej: assert property (p_rej) else $error("reject");
endmodule // plc_gates_chk
bind plc_basic_gates_and_flags plc_gates_chk u_chk (.*);

// ### tb/flag_partner.sv
// Partner that writes exchange flags over the link.
`timescale 1ns/10ps
module flag_partner (
   input  wire i_clk, i_go, input wire [22:0] i_req,
   output reg  o_wr = 1'b0, output reg [22:0] o_bus = 23'h000000
);
   always @(negedge i_clk) begin
      o_wr  <= i_go;
      o_bus <= i_go ? i_req : ~o_bus;
   end
endmodule // flag_partner

// ### tb/tb_top.sv
// Bench for the scan gate block.
`timescale 1ns/10ps
module tb_top;
   reg I_CLK = 0, I_RST = 1, I_SCAN = 0, I_COM_OK = 1, I_CFG_VALID = 0, go = 0, sq = 0;
   reg ap = 0, ep = 0, f = 1, a, e, I_CFG_ANALOG = 0;
   reg [3:0] I_GATE_IN = 0, I_GATE_USED = 0, I_GATE_INV = 0;
   reg [5:0] I_CFG_NUM = 0;
   reg [22:0] rq = 0;
   reg [31:0] s = 32'h0d98d4c0;
   reg [4:0] q [$];
   wire O_AND, O_AND_EDGE, O_NAND, O_CFG_REJECT, O_RD_DBIT, I_COM_WR, I_COM_ANALOG;
   wire [5:0] I_COM_NUM;
   wire [15:0] O_RD_AVAL, I_COM_AVAL;
   wire [63:0] O_DFLAGS;
   integer n_errors = 0, checked = 0, i;
   flag_partner P (.i_clk(I_CLK), .i_go(go), .i_req(rq), .o_wr(I_COM_WR),
      .o_bus({I_COM_ANALOG, I_COM_NUM, I_COM_AVAL}));
   plc_basic_gates_and_flags DUT (.I_CLK(I_CLK), .I_RST(I_RST), .I_SCAN(I_SCAN),
      .I_GATE_IN(I_GATE_IN), .I_GATE_USED(I_GATE_USED), .I_GATE_INV(I_GATE_INV),
      .O_AND(O_AND), .O_AND_EDGE(O_AND_EDGE), .O_NAND(O_NAND), .I_CFG_VALID(I_CFG_VALID),
      .I_CFG_NUM(I_CFG_NUM), .I_CFG_ANALOG(I_CFG_ANALOG), .O_CFG_REJECT(O_CFG_REJECT),
      .I_LOC_WR(I_COM_WR), .I_LOC_ANALOG(I_COM_ANALOG), .I_LOC_NUM(I_COM_NUM ^ 6'h01),
      .I_LOC_DBIT(I_COM_AVAL[0]), .I_LOC_AVAL(I_COM_AVAL), .I_COM_OK(I_COM_OK),
      .I_COM_WR(I_COM_WR), .I_COM_ANALOG(I_COM_ANALOG), .I_COM_NUM(I_COM_NUM),
      .I_COM_DBIT(I_COM_AVAL[0]), .I_COM_AVAL(I_COM_AVAL), .I_RD_NUM(I_CFG_NUM),
      .O_RD_DBIT(O_RD_DBIT), .O_RD_AVAL(O_RD_AVAL), .O_DFLAGS(O_DFLAGS));
   initial forever #4 I_CLK = ~I_CLK;
   function [31:0] xs(input [31:0] x);
      begin x = x ^ (x << 13); x = x ^ (x >> 17); xs = x ^ (x << 5); end
   endfunction
   task chk(input [16:0] x, input [16:0] g);
      begin
         checked = checked + 1;
         if (g !== x) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t exp %h got %h", $time, x, g);
         end
      end
   endtask
   task end_sim;
      begin
         $display("errors %0d checks %0d", n_errors, checked);
         if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   task send(input [22:0] r, input o);
      begin
         @(negedge I_CLK) begin go <= 1; rq <= r; I_COM_OK <= o; end
         @(negedge I_CLK) go <= 0;
         @(negedge I_CLK);
      end
   endtask
   always @(posedge I_CLK) sq <= I_SCAN;
   always @(negedge I_CLK) if (sq) chk(q.pop_front(), {O_AND, O_AND_EDGE, O_NAND,
      O_DFLAGS[7], O_DFLAGS[3]});
   initial begin
      repeat (12) @(negedge I_CLK);
      I_RST = 0;
      @(negedge I_CLK) begin I_CFG_VALID = 1; I_CFG_NUM = 5; end
      @(negedge I_CLK) begin I_CFG_VALID = 1; chk(0, O_CFG_REJECT); end
      @(negedge I_CLK) begin I_CFG_ANALOG = 1; chk(1, O_CFG_REJECT); end
      @(negedge I_CLK) begin I_CFG_VALID = 0; I_CFG_ANALOG = 0; chk(0, O_CFG_REJECT); end
      @(negedge I_CLK) chk(0, O_CFG_REJECT);
      send({1'b0, 6'd3, 16'h0001}, 1);
      send({1'b1, 6'd3, 16'h8001}, 1);
      send({1'b0, 6'd3, 16'h0000}, 0);
      send({1'b1, 6'd3, 16'h1234}, 0);
      for (i = 0; i < 80; i = i + 1) @(negedge I_CLK) begin
         s = xs(s);
         {I_GATE_USED, I_GATE_IN} = {s[3:0], s[7:4] | s[11:8]};
         I_GATE_INV = s[15:12] & s[19:16];
         I_SCAN = s[20] | s[21];
         if (I_SCAN) begin
            a = &(~I_GATE_USED | (I_GATE_IN ^ I_GATE_INV));
            e = a & ~ap & ~ep & ~f;
            q.push_back({a, e, ~a, f, 1'b1});
            {ap, ep, f} = {a, e, 1'b0};
         end
      end
      @(negedge I_CLK) begin I_SCAN = 0; I_CFG_NUM = 3; end
      repeat (2) @(negedge I_CLK);
      chk({1'b1, 16'h8001}, {O_RD_DBIT, O_RD_AVAL});
      end_sim;
   end
   initial begin
      #4000;
      n_errors = n_errors + 1;
      end_sim;
   end
endmodule // tb_top
